// [rtl/ptc_top.sv]
/*
 * Two-compare PWM timer: control, status flags, counter, compare
 * registers, PWM outputs and masked interrupt, behind an APB slave.
 * Assumes pclk drives the whole block and oscillator ticks are
 * single-cycle pulses already synchronous to pclk.
 */
`timescale 1ns/1ps
module ptc_top
   import ptc_pkg::*;
#(
   parameter int CNT_W = 16
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        osc_tick,
   input  wire logic        osc_fast_tick,
   output logic             pwm_a,
   output logic             pwm_b,
   output logic             irq
);
   logic [7:0]       ctrl0;
   logic [7:0]       ctrl1;
   logic             start;
   logic [3:0]       buf_sel;
   logic [CNT_W-1:0] cnt0;
   logic [CNT_W-1:0] gr [8];
   logic [IRQ_W-1:0] irq_st;
   logic [IRQ_W-1:0] irq_msk;
   logic [FLAG_W-1:0] flags0;
   logic [FLAG_W-1:0] flags1;
   logic [FLAG_W-1:0] set0;
   logic [FLAG_W-1:0] set1;
   logic             tick;
   logic             run;
   logic             period_match;
   logic             clr_on_a0;
   logic [CNT_W-1:0] next_cnt0;
   logic [31:0]      next_rdata;
   logic             next_err;
   logic             setup;
   logic             wr_done;
   logic             rd_done;
   logic [9:0]       idx;
   logic [7:0]       hit;
   logic             wr_ctrl0;
   logic             wr_ctrl1;
   logic             wr_start;
   logic             wr_bufsel;
   logic             wr_msk;
   logic             wr_irq_st;
   logic             wr_cnt0;
   logic             wr_gr;
   logic             wr_stat0;
   logic             wr_stat1;
   logic             rd_stat0;
   logic             rd_stat1;

   if (CNT_W < 2 || CNT_W > 32) begin : g_bad_cnt
      $error("ptc_top: CNT_W must lie in 2..32");
   end

   if (IRQ_W != 2 * FLAG_W) begin : g_bad_irq
      $error("ptc_top: IRQ_W must hold both flag sets");
   end

   // Register file is indexed by the low three index bits
   if (IDX_GR_BASE[2:0] != 3'h0) begin : g_bad_gr
      $error("ptc_top: IDX_GR_BASE must be a multiple of eight");
   end

   function automatic logic [7:0] status_byte(input logic b5,
                                              input logic [FLAG_W-1:0] f);
      status_byte = {STAT_HI, b5, f};
   endfunction

   function automatic logic is_gr(input logic [9:0] i);
      is_gr = (i >= IDX_GR_BASE) && (i < IDX_GR_BASE + 10'h008);
   endfunction

   function automatic logic strobe(input logic       done,
                                   input logic [9:0] at,
                                   input logic [9:0] want);
      strobe = done && (at == want);
   endfunction

   // Bus phases
   assign idx     = paddr[11:2];
   assign setup   = psel & ~penable;
   assign wr_done = psel & penable & pready & pwrite;
   assign rd_done = psel & penable & pready & ~pwrite;

   // Write strobes, one per writable register; the eight compare registers share one
   assign wr_ctrl0  = strobe(wr_done, idx, IDX_CTRL0);
   assign wr_ctrl1  = strobe(wr_done, idx, IDX_CTRL1);
   assign wr_start  = strobe(wr_done, idx, IDX_START);
   assign wr_bufsel = strobe(wr_done, idx, IDX_BUFSEL);
   assign wr_msk    = strobe(wr_done, idx, IDX_IRQ_MSK);
   assign wr_irq_st = strobe(wr_done, idx, IDX_IRQ_ST);
   assign wr_cnt0   = strobe(wr_done, idx, IDX_CNT0);
   assign wr_gr     = wr_done && is_gr(idx);
   assign wr_stat0  = strobe(wr_done, idx, IDX_STAT0);
   assign wr_stat1  = strobe(wr_done, idx, IDX_STAT1);

   // Status reads arm the zero-write clear
   assign rd_stat0  = strobe(rd_done, idx, IDX_STAT0);
   assign rd_stat1  = strobe(rd_done, idx, IDX_STAT1);

   // Count source and counting
   ptc_prescaler u_presc (
      .pclk          (pclk),
      .presetn       (presetn),
      .sel           (ctrl0[TCK_LSB +: 3]),
      .osc_tick      (osc_tick),
      .osc_fast_tick (osc_fast_tick),
      .tick          (tick)
   );

   // Only the first control register governs counting
   assign run          = start & tick;
   assign period_match = cnt0 == gr[GR_A];
   assign clr_on_a0    = ctrl0[CCLR_LSB +: 3] == CCLR_GRA0;

   always_comb begin
      next_cnt0 = cnt0;
      if (run) begin
         if (clr_on_a0 && period_match) begin
            next_cnt0 = '0;
         end else begin
            next_cnt0 = cnt0 + {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt0 <= '0;
      end else if (wr_cnt0) begin
         cnt0 <= pwdata[CNT_W-1:0];
      end else begin
         cnt0 <= next_cnt0;
      end
   end

   // Compare hits of all eight registers on a counting cycle
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         hit[i] = run && (cnt0 == gr[i]);
      end
   end

   // Match and overflow events on the counting cycle
   assign set0[0] = hit[GR_A];
   assign set0[1] = hit[GR_B];
   assign set0[2] = hit[GR_C];
   assign set0[3] = hit[GR_D];
   assign set0[4] = run & (&cnt0) & ~(clr_on_a0 & period_match);

   // Second channel compares its registers against the running counter
   assign set1[0] = hit[4 + GR_A];
   assign set1[1] = hit[4 + GR_B];
   assign set1[2] = hit[4 + GR_C];
   assign set1[3] = hit[4 + GR_D];
   assign set1[4] = 1'b0;

   ptc_flags #(
      .W (FLAG_W)
   ) u_flags0 (
      .pclk    (pclk),
      .presetn (presetn),
      .set     (set0),
      .rd_done (rd_stat0),
      .rd_val  (prdata[FLAG_W-1:0]),
      .wr_done (wr_stat0),
      .wr_val  (pwdata[FLAG_W-1:0]),
      .flags   (flags0)
   );

   ptc_flags #(
      .W (FLAG_W)
   ) u_flags1 (
      .pclk    (pclk),
      .presetn (presetn),
      .set     (set1),
      .rd_done (rd_stat1),
      .rd_val  (prdata[FLAG_W-1:0]),
      .wr_done (wr_stat1),
      .wr_val  (pwdata[FLAG_W-1:0]),
      .flags   (flags1)
   );

   // Control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl0 <= CTRL0_RST;
      end else if (wr_ctrl0) begin
         ctrl0 <= pwdata[7:0];
      end
   end

   // Stored for software only; never steers counting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl1 <= CTRL0_RST;
      end else if (wr_ctrl1) begin
         ctrl1 <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start <= 1'b0;
      end else if (wr_start) begin
         start <= pwdata[0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buf_sel <= 4'h0;
      end else if (wr_bufsel) begin
         buf_sel <= pwdata[3:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_msk <= '0;
      end else if (wr_msk) begin
         irq_msk <= pwdata[IRQ_W-1:0];
      end
   end

   // Compare registers; buffered C and D load A and B at period end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 8; i++) begin
            gr[i] <= '0;
         end
      end else begin
         if (run && period_match) begin
            for (int c = 0; c < 2; c++) begin
               if (buf_sel[2*c]) begin
                  gr[4*c + GR_A] <= gr[4*c + GR_C];
               end
               if (buf_sel[2*c + 1]) begin
                  gr[4*c + GR_B] <= gr[4*c + GR_D];
               end
            end
         end
         if (wr_gr) begin
            gr[idx[2:0]] <= pwdata[CNT_W-1:0];
         end
      end
   end

   // Output A: active from the channel-1 A point to the period end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_a <= 1'b0;
      end else if (hit[GR_A]) begin
         pwm_a <= 1'b0;
      end else if (hit[4 + GR_A]) begin
         pwm_a <= 1'b1;
      end
   end

   // Output B: active from the channel-1 B point to the channel-0 B point
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_b <= 1'b0;
      end else if (hit[GR_B]) begin
         pwm_b <= 1'b0;
      end else if (hit[4 + GR_B]) begin
         pwm_b <= 1'b1;
      end
   end

   // Interrupt: sticky events, write one to clear, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_st <= '0;
      end else begin
         irq_st <= (irq_st & ~(wr_irq_st ?
                               pwdata[IRQ_W-1:0] : '0)) | {set1, set0};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_st & irq_msk);
      end
   end

   // Read mux
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_err   = 1'b0;
      if (is_gr(idx)) begin
         next_rdata[CNT_W-1:0] = gr[idx[2:0]];
      end else begin
         unique case (idx)
            IDX_CTRL0:   next_rdata[7:0] = ctrl0;
            IDX_CTRL1:   next_rdata[7:0] = ctrl1;
            IDX_START:   next_rdata[0] = start;
            IDX_STAT0:   next_rdata[7:0] = status_byte(STAT0_B5, flags0);
            IDX_STAT1:   next_rdata[7:0] = status_byte(STAT1_B5, flags1);
            IDX_IRQ_ST:  next_rdata[IRQ_W-1:0] = irq_st;
            IDX_IRQ_MSK: next_rdata[IRQ_W-1:0] = irq_msk;
            IDX_BUFSEL:  next_rdata[3:0] = buf_sel;
            IDX_CNT0:    next_rdata[CNT_W-1:0] = cnt0;
            IDX_CNT1:    next_rdata = 32'h0000_0000;
            default:     next_err = 1'b1;
         endcase
      end
   end

   // One wait-free access phase: answer ready at the first access edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready <= setup;
         if (setup) begin
            pslverr <= next_err;
            prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
         end else if (pready) begin
            pslverr <= 1'b0;
         end
      end
   end
endmodule

// [rtl/ptc_pkg.sv]
/*
 * Constants of the two-compare PWM timer control and status block:
 * register indices, field positions, reset values and count codes.
 * Assumes a 32-bit APB with byte address = 4 * register index.
 */
package ptc_pkg;
   localparam logic [9:0] IDX_CTRL0   = 10'h140;
   localparam logic [9:0] IDX_START   = 10'h141;
   localparam logic [9:0] IDX_STAT0   = 10'h143;
   localparam logic [9:0] IDX_CTRL1   = 10'h150;
   localparam logic [9:0] IDX_STAT1   = 10'h153;
   localparam logic [9:0] IDX_IRQ_ST  = 10'h160;
   localparam logic [9:0] IDX_IRQ_MSK = 10'h161;
   localparam logic [9:0] IDX_BUFSEL  = 10'h163;
   localparam logic [9:0] IDX_CNT0    = 10'h164;
   localparam logic [9:0] IDX_CNT1    = 10'h165;
   localparam logic [9:0] IDX_GR_BASE = 10'h168;

   localparam int TCK_LSB  = 0;
   localparam int CKEG_LSB = 3;
   localparam int CCLR_LSB = 5;

   localparam logic [2:0] SRC_F1    = 3'h0;
   localparam logic [2:0] SRC_F2    = 3'h1;
   localparam logic [2:0] SRC_F4    = 3'h2;
   localparam logic [2:0] SRC_F8    = 3'h3;
   localparam logic [2:0] SRC_F32   = 3'h4;
   localparam logic [2:0] SRC_BAD   = 3'h5;
   localparam logic [2:0] SRC_OSC   = 3'h6;
   localparam logic [2:0] SRC_OSC_F = 3'h7;

   localparam logic [2:0] CCLR_GRA0 = 3'h1;

   localparam logic [7:0] CTRL0_RST  = 8'h00;
   localparam logic [1:0] STAT_HI    = 2'h3;
   localparam logic       STAT0_B5   = 1'b1;
   localparam logic       STAT1_B5   = 1'b0;
   localparam int         FLAG_W     = 5;
   localparam int         IRQ_W      = 10;

   localparam int GR_A = 0;
   localparam int GR_B = 1;
   localparam int GR_C = 2;
   localparam int GR_D = 3;
endpackage

// [rtl/ptc_prescaler.sv]
/*
 * Count source tick generator: one pclk pulse per count-source period.
 * Assumes oscillator tick inputs are single-cycle pulses synchronous to pclk.
 */
`timescale 1ns/1ps
module ptc_prescaler
   import ptc_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [2:0] sel,
   input  wire logic       osc_tick,
   input  wire logic       osc_fast_tick,
   output logic            tick
);
   logic [4:0] div;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div <= 5'h00;
      end else begin
         div <= div + 5'h01;
      end
   end

   // Divided clocks pulse when the low divider bits wrap
   always_comb begin
      unique case (sel)
         SRC_F1:    tick = 1'b1;
         SRC_F2:    tick = div[0];
         SRC_F4:    tick = &div[1:0];
         SRC_F8:    tick = &div[2:0];
         SRC_F32:   tick = &div;
         SRC_BAD:   tick = 1'b0;
         SRC_OSC:   tick = osc_tick;
         SRC_OSC_F: tick = osc_fast_tick;
      endcase
   end
endmodule

// [rtl/ptc_flags.sv]
/*
 * Read-then-write-zero status flags with hardware set priority.
 * Assumes read and write completions never coincide (APB).
 */
`timescale 1ns/1ps
module ptc_flags #(
   parameter int W = 5
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] set,
   input  wire logic         rd_done,
   input  wire logic [W-1:0] rd_val,
   input  wire logic         wr_done,
   input  wire logic [W-1:0] wr_val,
   output logic      [W-1:0] flags
);
   logic [W-1:0] armed;
   logic [W-1:0] clr;

   if (W < 1) begin : g_bad_w
      $error("ptc_flags: W must be at least 1");
   end

   // Only bits returned as one may be cleared by a zero write
   assign clr = wr_done ? (armed & ~wr_val) : '0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         armed <= '0;
      end else if (rd_done) begin
         armed <= rd_val;
      end else if (wr_done) begin
         armed <= '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags <= '0;
      end else begin
         flags <= (flags & ~clr) | set;
      end
   end
endmodule

// [test/ptc_assertions.sv]
/* Checker for ptc_top: APB timing, unmapped access, status read bits.
   Assumes one pclk domain and bind by ptc_top port names. */
`timescale 1ns/1ps
module ptc_chk
   import ptc_pkg::*;
#(
   parameter int CNT_W = 16
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        osc_tick,
   input wire logic        osc_fast_tick,
   input wire logic        pwm_a,
   input wire logic        pwm_b,
   input wire logic        irq
);
   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [9:0] idx;
   logic       rd;
   logic [7:0] shadow;
   assign idx = paddr[11:2];
   assign rd  = pready && psel && penable && !pwrite;
   // Last value written to control zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shadow <= CTRL0_RST;
      end else if (pready && psel && penable && pwrite && idx == IDX_CTRL0) begin
         shadow <= pwdata[7:0];
      end
   end
   ready_after_setup_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   unmapped_err_a: assert property (pready && idx < IDX_CTRL0 |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   ctrl0_read_a: assert property (rd && idx == IDX_CTRL0 |-> prdata[7:0] == shadow)
      else $error("control zero readback wrong");
   stat0_high_a: assert property (rd && idx == IDX_STAT0 |-> prdata[7:5] == 3'h7)
      else $error("status zero upper bits wrong");
   stat1_high_a: assert property (rd && idx == IDX_STAT1 |-> prdata[7:5] == 3'h6)
      else $error("status one upper bits wrong");
   read_upper_zero_a: assert property (rd |-> prdata[31:16] == 16'h0)
      else $error("upper read bits not zero");
   cover property (rd && idx == IDX_STAT0 && prdata[4]);
   cover property ($rose(irq));
   cover property (pslverr);
endmodule

bind ptc_top ptc_chk #(.CNT_W(CNT_W)) ptc_chk_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .osc_tick(osc_tick),
   .osc_fast_tick(osc_fast_tick), .pwm_a(pwm_a), .pwm_b(pwm_b), .irq(irq)
);

// [test/tb.sv]
/* Self-checking bench for ptc_top over APB.
   Assumes the bound checker and a 20 MHz pclk. */
`timescale 1ns/1ps
module tb
   import ptc_pkg::*;
();
   logic        pclk          = 1'b0;
   logic        presetn       = 1'b0;
   logic        psel          = 1'b0;
   logic        penable       = 1'b0;
   logic        pwrite        = 1'b0;
   logic [11:0] paddr         = 12'h0;
   logic [31:0] pwdata        = 32'h0;
   logic        osc_tick      = 1'b0;
   logic        osc_fast_tick = 1'b0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        pwm_a;
   logic        pwm_b;
   logic        irq;
   logic [31:0] q;
   logic        e;
   int          miscompares   = 0;
   int          num_checks    = 0;
   int          seed          = 2368;
   logic [15:0] gr [8]        = '{16'h9, 16'h5, 16'h3, 16'h7, 16'h2, 16'h4, 16'h64, 16'h64};

   always #25 pclk = ~pclk;

   ptc_top #(.CNT_W(16)) ptc_top_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .osc_tick(osc_tick),
      .osc_fast_tick(osc_fast_tick), .pwm_a(pwm_a), .pwm_b(pwm_b), .irq(irq)
   );

   function automatic logic [31:0] stat(input logic ch, input logic [4:0] f);
      return {24'h0, STAT_HI, ~ch, f};
   endfunction

   // Output levels after the counter stopped at c, period already wrapped
   function automatic logic [31:0] pwm_exp(input logic [15:0] c);
      logic [15:0] v;
      v = (c == 16'h0) ? gr[GR_A] : c - 16'h1;
      return {30'h0, v >= gr[4 + GR_B] && v < gr[GR_B], v >= gr[4 + GR_A] && v < gr[GR_A]};
   endfunction

   task check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task results();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task apb(input logic w, input logic [9:0] ix, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {ix, 2'h0};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         miscompares++;
         results();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task rdc(input logic [9:0] ix, input logic [31:0] exp);
      apb(1'b0, ix, 32'h0);
      check(q, exp);
   endtask

   initial begin
      logic [31:0] d;
      int          k;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rdc(IDX_CTRL0, 32'h0);
      rdc(IDX_STAT0, stat(1'b0, 5'h0));
      rdc(IDX_STAT1, stat(1'b1, 5'h0));
      $display("reset values done");
      for (k = 0; k < 8; k++) begin
         d = {24'h0, CCLR_GRA0, 2'(k), 3'((k == 5) ? 6 : k)};
         apb(1'b1, IDX_CTRL0, d);
         rdc(IDX_CTRL0, d);
      end
      apb(1'b0, 10'h0, 32'h0);
      check({q[31:1], e}, 32'h1);
      for (k = 0; k < 8; k++) begin
         d = $random(seed);
         apb(1'b1, IDX_GR_BASE + 10'(k), d);
         rdc(IDX_GR_BASE + 10'(k), d & 32'hFFFF);
      end
      $display("registers done");
      for (k = 0; k < 8; k++) begin
         apb(1'b1, IDX_GR_BASE + 10'(k), {16'h0, gr[k]});
      end
      apb(1'b1, IDX_CTRL1, 32'hFF);
      apb(1'b1, IDX_CNT0, 32'h0);
      apb(1'b1, IDX_CTRL0, {24'h0, CCLR_GRA0, 2'h0, SRC_F1});
      apb(1'b1, IDX_START, 32'h1);
      repeat (30) @(posedge pclk);
      apb(1'b1, IDX_START, 32'h0);
      apb(1'b0, IDX_CNT0, 32'h0);
      check({31'h0, q <= 32'h9}, 32'h1);
      check({30'h0, pwm_b, pwm_a}, pwm_exp(q[15:0]));
      apb(1'b1, IDX_STAT0, 32'h0);
      rdc(IDX_STAT0, stat(1'b0, 5'h0F));
      rdc(IDX_STAT1, stat(1'b1, 5'h03));
      rdc(IDX_IRQ_ST, 32'h06F);
      apb(1'b1, IDX_IRQ_MSK, 32'h001);
      repeat (2) @(posedge pclk);
      check({31'h0, irq}, 32'h1);
      apb(1'b1, IDX_IRQ_ST, 32'h3FF);
      repeat (2) @(posedge pclk);
      check({31'h0, irq}, 32'h0);
      rdc(IDX_IRQ_ST, 32'h0);
      $display("match flags done");
      apb(1'b1, IDX_STAT0, 32'h1F);
      rdc(IDX_STAT0, stat(1'b0, 5'h0F));
      apb(1'b1, IDX_STAT0, 32'h1E);
      rdc(IDX_STAT0, stat(1'b0, 5'h0E));
      apb(1'b1, IDX_CNT0, 32'hFFFE);
      apb(1'b1, IDX_START, 32'h1);
      repeat (6) @(posedge pclk);
      apb(1'b1, IDX_START, 32'h0);
      apb(1'b1, IDX_STAT0, 32'h0);
      apb(1'b0, IDX_STAT0, 32'h0);
      check({31'h0, q[4]}, 32'h1);
      apb(1'b1, IDX_STAT0, 32'h0);
      rdc(IDX_STAT0, stat(1'b0, 5'h0));
      $display("flag clearing done");
      for (k = 0; k < 2; k++) begin
         apb(1'b1, IDX_CNT0, 32'h0);
         apb(1'b1, IDX_CTRL0, {24'h0, CCLR_GRA0, 2'h0, k ? SRC_OSC_F : SRC_OSC});
         apb(1'b1, IDX_START, 32'h1);
         for (int p = 0; p < 5; p++) begin
            @(posedge pclk);
            osc_tick <= 1'b1;
            osc_fast_tick <= (p < 3);
            @(posedge pclk);
            osc_tick <= 1'b0;
            osc_fast_tick <= 1'b0;
         end
         apb(1'b1, IDX_START, 32'h0);
         rdc(IDX_CNT0, k ? 32'h3 : 32'h5);
      end
      rdc(IDX_CNT1, 32'h0);
      $display("count sources done");
      results();
   end
endmodule
